// file: bench/srcp_bus_ctl.sv
module srcp_bus_ctl (
  input  wire logic i_mclk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic low;
  // pull-up: a released line reads high
  assign o_sda = !(low || i_sda_oe);
  initial
  begin
    o_scl = 1'b1;
    low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : w
  task automatic start();
    o_scl <= 1'b0;
    w(2);
    low <= 1'b0;
    w(2);
    o_scl <= 1'b1;
    w(2);
    low <= 1'b1;
    w(2);
    o_scl <= 1'b0;
  endtask : start
  task automatic bit_io(input logic b, output logic s);
    o_scl <= 1'b0;
    w(2);
    low <= !b;
    w(2);
    o_scl <= 1'b1;
    w(2);
    // sample away from the edge where the slave updates
    @(negedge i_mclk);
    s = o_sda;
    w(2);
  endtask : bit_io
  // byte out msb first, ninth bit
  task automatic xfer(input logic [7:0] d, input logic nak,
                      output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(nak, s);
    ack = !s;
  endtask : xfer
  task automatic stop();
    o_scl <= 1'b0;
    w(2);
    low <= 1'b1;
    w(2);
    o_scl <= 1'b1;
    w(2);
    low <= 1'b0;
    w(4);
  endtask : stop
endmodule : srcp_bus_ctl

// file: bench/srcp_checker.sv
module srcp_checker
  import srcp_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 200000
)(
  input wire logic          i_mclk,
  input wire logic          i_nrst,
  input wire logic          i_scl,
  input wire logic          i_sda,
  input wire logic [13:0]   i_factory_range_word,
  input wire logic          i_nv_recall,
  input wire srcp_regs_t    i_nv_image,
  input wire logic          o_sda_out,
  input wire logic          o_sda_oe,
  input wire srcp_regs_t    o_regs,
  input wire logic [10:0]   o_divisor,
  input wire logic [2:0]    o_dev_select,
  input wire logic          o_eeprom_write_defer,
  input wire logic          o_nv_write,
  input wire srcp_nv_mask_t o_nv_mask,
  input wire srcp_regs_t    o_nv_image,
  input wire logic          o_nv_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  int unsigned busy_len;
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      busy_len <= 0;
    else if (o_nv_busy)
      busy_len <= busy_len + 1;
    else
      busy_len <= 0;
  sequence s_store;
    o_nv_write ##1 (o_nv_busy && !o_nv_write);
  endsequence
  AST_STORE_SEQ: assert property (o_nv_write |-> s_store)
    else $error("store pulse not followed by busy");
  AST_BUSY_LEN: assert property
    ($fell(o_nv_busy) |-> busy_len == NV_WRITE_CYCLES)
    else $error("busy window length wrong");
  AST_NO_ACK_BUSY: assert property
    (o_nv_busy |-> !$rose(o_sda_oe))
    else $error("acknowledge while store busy");
  AST_DIVISOR: assert property
    (o_divisor == {1'b0, o_regs.divider_word} + 11'h002)
    else $error("divisor not value plus two");
  AST_DEVSEL: assert property
    (o_dev_select == o_regs.bus_select_byte[2:0])
    else $error("device select mismatch");
  AST_DEFER: assert property
    (o_eeprom_write_defer == o_regs.bus_select_byte[4])
    else $error("defer flag mismatch");
  AST_DEFER_MASK: assert property
    (o_nv_write && o_eeprom_write_defer
      |=> !o_nv_mask.trim && !o_nv_mask.offset)
    else $error("deferred store took trim or offset");
  AST_MASK_HELD: assert property
    (!o_nv_write && !$past(o_nv_write)
      |-> $stable(o_nv_mask) && $stable(o_nv_image))
    else $error("store mask or image moved");
  AST_ODRAIN: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
endmodule : srcp_checker

bind srcp_top srcp_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .i_mclk, .i_nrst, .i_scl, .i_sda, .i_factory_range_word, .i_nv_recall,
  .i_nv_image, .o_sda_out, .o_sda_oe, .o_regs, .o_divisor, .o_dev_select,
  .o_eeprom_write_defer, .o_nv_write, .o_nv_mask, .o_nv_image, .o_nv_busy);

// file: bench/synth_register_command_port_bench.sv
`include "srcp_cfg.svh"
module synth_register_command_port_bench
  import srcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          NVC = 200;
  localparam logic [13:0] RNG = 14'h2A5F;
  logic          i_mclk = 1'b0;
  logic          i_nrst = 1'b0;
  logic          scl, sda, oe, nvw, nvd, busy, ack;
  logic          seen = 1'b0;
  srcp_regs_t    regs;
  srcp_nv_mask_t mask, smask;
  logic [10:0]   divisor;
  logic [2:0]    dsel;
  logic [2:0]    dev = 3'h0;
  logic [7:0]    q;
  int            mismatches = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  always #25 i_mclk = ~i_mclk;
  srcp_top #(.NV_WRITE_CYCLES(NVC)) dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
    .i_factory_range_word(RNG), .i_nv_recall(1'b0), .i_nv_image('0),
    .o_sda_out(), .o_sda_oe(oe), .o_regs(regs), .o_divisor(divisor),
    .o_dev_select(dsel), .o_eeprom_write_defer(), .o_nv_write(nvw),
    .o_nv_mask(mask), .o_nv_image(), .o_nv_busy(busy));
  srcp_bus_ctl ctl (.i_mclk(i_mclk), .i_sda_oe(oe), .o_scl(scl),
    .o_sda(sda));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    nvd <= nvw;
    if (nvw === 1'b1)
      seen <= 1'b1;
    if (nvd === 1'b1)
      smask <= mask;
    if (cyc == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic ctrl(input logic rw, input logic ea);
    ctl.start();
    ctl.xfer({`SRCP_TYPE_CODE, dev, rw}, 1'b1, q, ack);
    chk(16'(ack), 16'(ea));
  endtask : ctrl
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    seen <= 1'b0;
    ctrl(1'b0, 1'b1);
    ctl.xfer(c, 1'b1, q, ack);
    chk(16'(ack), 16'h0001);
    for (int i = 0; i < n; i++)
      ctl.xfer(d[15 - 8 * i -: 8], 1'b1, q, ack);
    ctl.stop();
  endtask : wr
  task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e);
    ctrl(1'b0, 1'b1);
    ctl.xfer(c, 1'b1, q, ack);
    ctrl(1'b1, 1'b1);
    ctl.xfer(8'hFF, n == 1, q, ack);
    chk(16'(q), 16'(e[15:8]));
    if (n == 2)
    begin
      ctl.xfer(8'hFF, 1'b1, q, ack);
      chk(16'(q), 16'(e[7:0]));
    end
    ctl.stop();
  endtask : rd
  task automatic settle();
    repeat (NVC + 20) @(posedge i_mclk);
  endtask : settle
  task automatic t_reset();
    chk(16'(divisor), 16'd2);
    chk(16'(regs.output_mode_word), 16'h0060);
    chk(16'(dsel), 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    logic [7:0]  c[4] = '{8'h01, 8'h02, 8'h08, 8'h0E};
    logic [15:0] d[4] = '{16'hFFC0, 16'h5A7F, 16'hA5FF, 16'hEA00};
    logic [15:0] e[4] = '{16'hFFC0, 16'h5A40, 16'hA5C0, 16'hEA00};
    int          n[4] = '{2, 2, 2, 1};
    for (int i = 0; i < 4; i++)
    begin
      wr(c[i], n[i], d[i]);
      settle();
      chk(16'(seen), 16'h0001);
      rd(c[i], n[i], e[i]);
    end
    chk(16'(smask), 16'h0001);
    chk(16'(divisor), 16'd1025);
    chk(16'(regs.freq_trim_word), 16'h0297);
    chk(16'(regs.range_offset_byte), 16'h000A);
    $display("test registers done");
  endtask : t_regs
  task automatic t_busy();
    wr(8'h01, 2, 16'h0100);
    ctrl(1'b0, 1'b0);
    chk(16'(busy), 16'h0001);
    ctl.stop();
    settle();
    chk(16'(busy), 16'h0000);
    chk(16'(regs.divider_word), 16'h0004);
    $display("test busy done");
  endtask : t_busy
  task automatic t_range();
    rd(8'h37, 2, {RNG[13:6], RNG[5:1], 3'h0});
    wr(8'h37, 2, 16'h0000);
    settle();
    rd(8'h37, 2, {RNG[13:6], RNG[5:1], 3'h0});
    $display("test range done");
  endtask : t_range
  task automatic t_abort();
    wr(8'h08, 1, 16'h1200);
    settle();
    chk(16'(regs.freq_trim_word), 16'h0297);
    chk(16'(seen), 16'h0000);
    $display("test abort done");
  endtask : t_abort
  task automatic t_defer();
    wr(8'h0D, 1, 16'h1000);
    settle();
    chk(16'(smask), 16'h0002);
    wr(8'h08, 2, 16'h0000);
    settle();
    chk(16'(smask.trim), 16'h0000);
    chk(16'(seen), 16'h0000);
    chk(16'(regs.freq_trim_word), 16'h0000);
    ctrl(1'b0, 1'b1);
    ctl.xfer(`SRCP_CMD_COMMIT, 1'b1, q, ack);
    ctl.stop();
    settle();
    chk(16'(smask), 16'h0018);
    $display("test defer done");
  endtask : t_defer
  task automatic t_addr();
    wr(8'h0D, 1, 16'hE500);
    settle();
    chk(16'(dsel), 16'h0005);
    ctrl(1'b0, 1'b0);
    ctl.stop();
    dev = 3'h5;
    rd(8'h0D, 1, 16'h0500);
    $display("test address done");
  endtask : t_addr
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    t_reset();
    t_regs();
    t_busy();
    t_range();
    t_abort();
    t_defer();
    t_addr();
    stop_test();
  end
endmodule : synth_register_command_port_bench

// file: logic/srcp_cfg.svh
`ifndef SRCP_CFG_SVH
`define SRCP_CFG_SVH

// command codes, used as register selectors
`define SRCP_CMD_DIVIDER   8'h01
`define SRCP_CMD_MODE      8'h02
`define SRCP_CMD_TRIM      8'h08
`define SRCP_CMD_BUS_SEL   8'h0D
`define SRCP_CMD_OFFSET    8'h0E
`define SRCP_CMD_RANGE     8'h37
`define SRCP_CMD_COMMIT    8'h3F

// control byte: type code is arbitrary here
`define SRCP_TYPE_CODE     4'hA
`define SRCP_TYPE_MSB      7
`define SRCP_TYPE_LSB      4
`define SRCP_DEVSEL_MSB    3
`define SRCP_DEVSEL_LSB    1
`define SRCP_RW_BIT        0

// bus_select_byte fields
`define SRCP_DEFER_BIT     4
`define SRCP_DEVSEL_HI     2

// reset values
`define SRCP_DIVIDER_RST   10'h000
`define SRCP_MODE_RST      10'h060
`define SRCP_TRIM_RST      10'h000
`define SRCP_BUS_SEL_RST   5'h00
`define SRCP_OFFSET_RST    5'h00

// divisor is value plus this
`define SRCP_DIV_BIAS      11'h002

// nonvolatile write time
`define SRCP_NV_WRITE_MS   10
`define SRCP_MCLK_HZ       20000000
`define SRCP_NV_CYCLES     (`SRCP_NV_WRITE_MS * (`SRCP_MCLK_HZ / 1000))

`endif

// file: logic/srcp_pkg.sv
package srcp_pkg;

  typedef struct packed {
    logic [9:0] divider_word;
    logic [9:0] output_mode_word;
    logic [9:0] freq_trim_word;
    logic [4:0] bus_select_byte;
    logic [4:0] range_offset_byte;
  } srcp_regs_t;

  typedef struct packed {
    logic divider;
    logic mode;
    logic trim;
    logic bus_sel;
    logic offset;
  } srcp_nv_mask_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } srcp_state_t;

endpackage : srcp_pkg

// file: logic/srcp_top.sv
// Behaviour
// - divisor equals divider value plus two
// - select bits form low address bits
// - defer clear: store after each write
// - defer set: store only on commit, except bus select writes
// - bus select always stored after write
// - factory range word read only
// - range read: high byte, then low bits
// - write: control, command, data; ack each
// - read: command, repeated start, control read
// - trim word two bytes, left aligned
// - offset byte five bits, top reads ones
// - divider word two bytes, left aligned
// - mode word two bytes, left aligned
// - bus select five bits, top reads zero
// - commit stores divider and mode words
// - ack control only on type and select
// - nack everything while nonvolatile write busy
`include "srcp_cfg.svh"

module srcp_top
  import srcp_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `SRCP_NV_CYCLES
)(
  input  wire logic          i_mclk,
  input  wire logic          i_nrst,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  input  wire logic [13:0]   i_factory_range_word,
  input  wire logic          i_nv_recall,
  input  wire srcp_regs_t    i_nv_image,
  output logic               o_sda_out,
  output logic               o_sda_oe,
  output srcp_regs_t         o_regs,
  output logic [10:0]        o_divisor,
  output logic [2:0]         o_dev_select,
  output logic               o_eeprom_write_defer,
  output logic               o_nv_write,
  output srcp_nv_mask_t      o_nv_mask,
  output srcp_regs_t         o_nv_image,
  output logic               o_nv_busy
);

  localparam int NV_CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  function automatic logic [7:0] rd_byte(
    input logic [7:0]  cmd,
    input logic        idx,
    input srcp_regs_t  r,
    input logic [13:0] rng
  );
    logic [9:0] w;
    w = 10'h000;
    rd_byte = 8'hFF;
    unique case (cmd)
      `SRCP_CMD_DIVIDER: w = r.divider_word;
      `SRCP_CMD_MODE:    w = r.output_mode_word;
      `SRCP_CMD_TRIM:    w = r.freq_trim_word;
      default:           w = 10'h000;
    endcase
    unique case (cmd)
      `SRCP_CMD_DIVIDER, `SRCP_CMD_MODE, `SRCP_CMD_TRIM:
        rd_byte = idx ? {w[1:0], 6'h00} : w[9:2];
      `SRCP_CMD_OFFSET:  rd_byte = {3'h7, r.range_offset_byte};
      `SRCP_CMD_BUS_SEL: rd_byte = {3'h0, r.bus_select_byte};
      `SRCP_CMD_RANGE:   rd_byte = idx ? {rng[5:1], 3'h0} : rng[13:6];
      default:           rd_byte = 8'hFF;
    endcase
  endfunction : rd_byte

  function automatic logic is_two_byte(input logic [7:0] cmd);
    is_two_byte = (cmd == `SRCP_CMD_DIVIDER) || (cmd == `SRCP_CMD_MODE)
                || (cmd == `SRCP_CMD_TRIM);
  endfunction : is_two_byte

  // pin synchronisers, third stage only for edge finding
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  srcp_state_t   state;
  srcp_regs_t    regs;
  srcp_nv_mask_t pend_mask;
  logic [7:0]    shreg;
  logic [7:0]    cmd;
  logic [7:0]    tx;
  logic [7:0]    hold;
  logic [3:0]    bit_cnt;
  logic          byte_idx;
  logic          mstr_nack;
  logic          commit_req;
  logic [NV_CNT_W-1:0] nv_cnt;

  wire nv_busy = (nv_cnt != '0);

  wire addr_hit =
    (shreg[`SRCP_TYPE_MSB:`SRCP_TYPE_LSB] == `SRCP_TYPE_CODE) &&
    (shreg[`SRCP_DEVSEL_MSB:`SRCP_DEVSEL_LSB] ==
     regs.bus_select_byte[`SRCP_DEVSEL_HI:0]) && !nv_busy;

  wire defer = regs.bus_select_byte[`SRCP_DEFER_BIT];

  wire srcp_nv_mask_t auto_mask = defer
    ? srcp_nv_mask_t'{divider: 1'b0, mode: 1'b0, trim: 1'b0,
        bus_sel: pend_mask.bus_sel, offset: 1'b0}
    : pend_mask;
  wire srcp_nv_mask_t store_mask = '{
    divider: auto_mask.divider | commit_req,
    mode:    auto_mask.mode | commit_req,
    trim:    auto_mask.trim,
    bus_sel: auto_mask.bus_sel,
    offset:  auto_mask.offset};
  wire frame_end = (start_ev | stop_ev) && state != ST_IDLE;
  wire nv_start  = frame_end && (store_mask != '0) && !nv_busy;

  wire [7:0] next_tx = rd_byte(cmd, byte_idx, regs, i_factory_range_word);

  // write path: one-byte registers commit at once, two-byte at the second
  wire        wr_byte   = scl_fall && bit_cnt == 4'd7 && state == ST_WDATA;
  wire        two_byte  = is_two_byte(cmd);
  wire        wr_commit = wr_byte && (two_byte ? byte_idx : !byte_idx);
  wire [9:0]  wr_word   = {hold, shreg[7:6]};

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      regs <= '{divider_word:      `SRCP_DIVIDER_RST,
                output_mode_word:  `SRCP_MODE_RST,
                freq_trim_word:    `SRCP_TRIM_RST,
                bus_select_byte:   `SRCP_BUS_SEL_RST,
                range_offset_byte: `SRCP_OFFSET_RST};
    end
    else if (i_nv_recall)
    begin
      regs <= i_nv_image;
    end
    else if (wr_commit)
    begin
      unique case (cmd)
        `SRCP_CMD_TRIM:    regs.freq_trim_word <= wr_word;
        `SRCP_CMD_DIVIDER: regs.divider_word <= wr_word;
        `SRCP_CMD_MODE:    regs.output_mode_word <= wr_word;
        `SRCP_CMD_OFFSET:  regs.range_offset_byte <= shreg[4:0];
        `SRCP_CMD_BUS_SEL: regs.bus_select_byte <= shreg[4:0];
        default:           regs <= regs;
      endcase
    end
  end

  // bit engine
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state      <= ST_IDLE;
      shreg      <= 8'h00;
      cmd        <= 8'h00;
      tx         <= 8'hFF;
      hold       <= 8'h00;
      bit_cnt    <= 4'd0;
      byte_idx   <= 1'b0;
      mstr_nack  <= 1'b0;
      o_sda_oe   <= 1'b0;
    end
    else if (start_ev)
    begin
      state    <= ST_ADDR;
      bit_cnt  <= 4'hF;  // start's own scl fall wraps to 0
      o_sda_oe <= 1'b0;
    end
    else if (stop_ev)
    begin
      state    <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (state != ST_IDLE && state != ST_IGNORE)
    begin
      if (scl_rise && bit_cnt < 4'd8)
      begin
        shreg <= {shreg[6:0], sda_s};
      end
      else if (scl_rise && state == ST_RDATA)
      begin
        mstr_nack <= sda_s;
      end
      if (scl_fall)
      begin
        if (bit_cnt == 4'd7)
        begin
          bit_cnt <= 4'd8;
          unique case (state)
            ST_ADDR:
            begin
              o_sda_oe  <= addr_hit;
              byte_idx  <= 1'b0;
              mstr_nack <= 1'b0;
              state     <= !addr_hit ? ST_IGNORE :
                           shreg[`SRCP_RW_BIT] ? ST_RDATA : ST_CMD;
            end
            ST_CMD:
            begin
              o_sda_oe <= 1'b1;
              cmd      <= shreg;
              state    <= ST_WDATA;
            end
            ST_WDATA:
            begin
              o_sda_oe <= 1'b1;
              hold     <= shreg;
              byte_idx <= ~byte_idx;
            end
            default:
            begin
              o_sda_oe <= 1'b0;
            end
          endcase
        end
        else if (bit_cnt == 4'd8)
        begin
          bit_cnt <= 4'd0;
          if (state == ST_RDATA && !mstr_nack)
          begin
            tx       <= next_tx;
            o_sda_oe <= ~next_tx[7];
            byte_idx <= ~byte_idx;
          end
          else
          begin
            o_sda_oe <= 1'b0;
            if (state == ST_RDATA)
            begin
              state <= ST_IGNORE;
            end
          end
        end
        else
        begin
          bit_cnt <= bit_cnt + 4'd1;
          if (state == ST_RDATA)
          begin
            tx       <= {tx[6:0], 1'b1};
            o_sda_oe <= ~tx[6];
          end
        end
      end
    end
  end

  // store bookkeeping and nonvolatile write timer
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pend_mask  <= '0;
      commit_req <= 1'b0;
      nv_cnt     <= '0;
      o_nv_write <= 1'b0;
      o_nv_mask  <= '0;
      o_nv_image <= '0;
    end
    else
    begin
      o_nv_write <= nv_start;
      if (nv_start)
      begin
        // busy span the controller must wait out
        nv_cnt     <= NV_CNT_W'(NV_WRITE_CYCLES);
        o_nv_mask  <= store_mask;
        o_nv_image <= regs;
      end
      else if (nv_busy)
      begin
        nv_cnt <= nv_cnt - NV_CNT_W'(1);
      end
      if (frame_end)
      begin
        pend_mask  <= '0;
        commit_req <= 1'b0;
      end
      else
      begin
        if (wr_commit)
        begin
          pend_mask.divider <= pend_mask.divider |
                               (cmd == `SRCP_CMD_DIVIDER);
          pend_mask.mode    <= pend_mask.mode | (cmd == `SRCP_CMD_MODE);
          pend_mask.trim    <= pend_mask.trim | (cmd == `SRCP_CMD_TRIM);
          pend_mask.bus_sel <= pend_mask.bus_sel |
                               (cmd == `SRCP_CMD_BUS_SEL);
          pend_mask.offset  <= pend_mask.offset |
                               (cmd == `SRCP_CMD_OFFSET);
        end
        // commit taken when the command byte lands
        if (scl_fall && bit_cnt == 4'd7 && state == ST_CMD &&
            shreg == `SRCP_CMD_COMMIT)
        begin
          commit_req <= 1'b1;
        end
      end
    end
  end

  // outputs all registered
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_regs               <= '0;
      o_divisor            <= `SRCP_DIV_BIAS;
      o_dev_select         <= 3'h0;
      o_eeprom_write_defer <= 1'b0;
      o_nv_busy            <= 1'b0;
      o_sda_out            <= 1'b0;
    end
    else
    begin
      o_regs               <= regs;
      o_divisor            <= {1'b0, regs.divider_word} + `SRCP_DIV_BIAS;
      o_dev_select         <= regs.bus_select_byte[`SRCP_DEVSEL_HI:0];
      o_eeprom_write_defer <= defer;
      o_nv_busy            <= nv_busy;
      o_sda_out            <= 1'b0;
    end
  end

endmodule : srcp_top
